// [hdl/scg_pkg.sv]
// Constants and types shared by the system clock generation block
//------------------------------------------------------------------
// Functional notes
// - Reset disables every source except low-power oscillator
// - System clock restarts from 2MHz oscillator
// - Prescaler changes accepted any time, source changes only onto a running source
// - Prescaler divides by 1 to 2048
// - Fast peripheral ticks at 2x, 4x CPU
// - PLL factor selectable from 1 to 31
// - PLL output 20-128MHz, lock detector reported
// - Failure moves clock to 2MHz, raises NMI if enabled
// - Detect crystal loss and PLL unlock; NMI optional
// - Low-power oscillator runs only while used
// - 32.768kHz calibration writable at run time
// - 32.768kHz divider gives 32.768kHz and 1.024kHz
// - 32.768kHz crystal: system, RTC, loop reference
// - Main crystal has four frequency range modes
// - Lock loop trims 2MHz oscillator calibration
// - 32MHz oscillator tunable 30-55MHz, own loop
// - Factory 48MHz calibration readable and loadable
// - Main crystal pin accepts external clock
// - CPU clock gated by idle and power-down sleep, peripheral clocks by power-down and power-reduction bits
//------------------------------------------------------------------
package scg_pkg;

  // Selectable system clock sources, index also used for ready/enable vectors
  typedef enum logic [2:0] {
    SRC_RC2M,
    SRC_RC32M,
    SRC_RC32K,
    SRC_XOSC,
    SRC_XTAL32K,
    SRC_PLL
  } scg_src_e;

  // RTC clock sources
  typedef enum logic [1:0] {
    RTC_ULP,
    RTC_RC32K,
    RTC_XTAL32K,
    RTC_OFF
  } scg_rtc_e;

  localparam int          NUM_SRC        = 6;
  localparam int          SYNC_W         = 10;
  localparam logic [3:0]  DIV_EXP_MAX    = 4'hb;     // 2^11 = 2048
  localparam logic [4:0]  PLL_MULT_MIN   = 5'h01;
  localparam logic [4:0]  PLL_MULT_MAX   = 5'h1f;
  localparam logic [21:0] PLL_KHZ_MIN    = 22'h004e20; // 20000 kHz
  localparam logic [21:0] PLL_KHZ_MAX    = 22'h01f400; // 128000 kHz
  localparam logic [16:0] RC2M_KHZ       = 17'h007d0;  // 2000 kHz
  localparam logic [16:0] RC32M_DIV4_KHZ = 17'h01f40;  // 8000 kHz
  localparam logic [4:0]  RC1K_DIV_LAST  = 5'h1f;      // 32.768k / 32
  localparam logic [7:0]  DIGITAL_FREQ_LOCK_LOOP_2M_TARGET = 8'h3d;      // 2MHz / 32.768kHz
  localparam logic [7:0]  RC2M_CAL_RST   = 8'h40;
  localparam logic [7:0]  RC32M_CAL_RST  = 8'h40;
  localparam logic [7:0]  RC32K_CAL_RST  = 8'h80;
  localparam logic [5:0]  OSC_EN_RST     = 6'h00;

endpackage

// [hdl/scg_clock_ctrl.sv]
// System clock selection, prescaling, calibration loops and failure monitor
`timescale 1ns/1ps

module scg_clock_ctrl #(
  parameter int         PER_N     = 8,       // Number of gated peripheral clocks
  parameter int         XOSC_KHZ  = 16000,   // Crystal frequency seen by the PLL
  parameter logic [7:0] USB48_CAL = 8'h9c    // Factory 48MHz trim, value arbitrary
) (
  // Clock and reset
  input  logic              clock_in,
  input  logic              sys_rst_in,
  // Source selection and enables from software
  input  logic [2:0]        req_src_in,
  input  logic [5:0]        osc_sw_en_in,
  input  logic [1:0]        rtc_src_in,
  input  logic              ulp_user_in,
  input  logic [1:0]        xosc_mode_in,
  input  logic              xosc_ext_clk_in,
  input  logic              xtal32k_low_swing_in,
  // Prescaler
  input  logic [3:0]        div_exp_in,
  // PLL
  input  logic              pll_sw_en_in,
  input  logic [4:0]        pll_mult_in,
  input  logic [1:0]        pll_ref_in,
  // Calibration
  input  logic [2:0]        cal_wr_in,
  input  logic [7:0]        cal_data_in,
  input  logic              usb48_load_in,
  input  logic [1:0]        digital_freq_lock_loop_en_in,
  input  logic              digital_freq_lock_loop_ref_in,
  input  logic [7:0]        dfll32_target_in,
  // Failure monitor
  input  logic              fail_mon_en_in,
  input  logic              nmi_en_in,
  input  logic              fail_clr_in,
  // Sleep and power reduction
  input  logic              idle_sleep_in,
  input  logic              pdown_sleep_in,
  input  logic [PER_N-1:0]  pwr_reduce_in,
  // Asynchronous status from the analog parts
  input  logic [4:0]        osc_ready_in,
  input  logic              pll_lock_in,
  input  logic              rc32k_clk_in,
  input  logic              xtal32k_clk_in,
  input  logic              fb2m_in,
  input  logic              fb32m_in,
  // Source control outputs
  output logic [2:0]        sys_src_out,
  output logic [5:0]        osc_en_out,
  output logic              ulp_en_out,
  output logic [1:0]        rtc_src_out,
  output logic [1:0]        xosc_mode_out,
  output logic              xosc_ext_clk_out,
  output logic              xtal32k_low_swing_out,
  // Prescaled ticks and gating
  output logic              per4_tick_out,
  output logic              per2_tick_out,
  output logic              cpu_tick_out,
  output logic              cpu_clk_en_out,
  output logic [PER_N-1:0]  per_clk_en_out,
  // PLL
  output logic [4:0]        pll_mult_out,
  output logic              pll_locked_out,
  // Calibration values
  output logic [7:0]        rc2m_cal_out,
  output logic [7:0]        rc32m_cal_out,
  output logic [7:0]        rc32k_cal_out,
  output logic [7:0]        usb48_cal_out,
  output logic              rc32k_tick_out,
  output logic              rc1k_tick_out,
  // Failure status
  output logic              xosc_fail_out,
  output logic              pll_fail_out,
  output logic              nmi_out
);

  //----------------------------------------------------------------
  // Input synchronisers
  //----------------------------------------------------------------
  logic [scg_pkg::SYNC_W-1:0] raw;
  logic [scg_pkg::SYNC_W-1:0] sync1_r;
  logic [scg_pkg::SYNC_W-1:0] sync2_r;
  logic [scg_pkg::SYNC_W-1:0] sync3_r;
  logic [scg_pkg::NUM_SRC-1:0] rdy;
  logic                       rc32k_rise;
  logic                       xtal32k_rise;
  logic [1:0]                 fb_rise;

  assign raw = {fb32m_in, fb2m_in, xtal32k_clk_in, rc32k_clk_in, pll_lock_in, osc_ready_in};

  // Two stages before use; third stage only feeds edge detectors
  always_ff @(posedge clock_in) begin
    sync1_r <= raw;
    sync2_r <= sync1_r;
    sync3_r <= sync2_r;
  end

  assign rdy          = sync2_r[5:0];
  assign rc32k_rise   = sync2_r[6] & ~sync3_r[6];
  assign xtal32k_rise = sync2_r[7] & ~sync3_r[7];
  assign fb_rise      = sync2_r[9:8] & ~sync3_r[9:8];

  //----------------------------------------------------------------
  // Failure monitor
  //----------------------------------------------------------------
  logic xosc_seen_r;
  logic pll_seen_r;
  logic xosc_loss;
  logic pll_loss;
  logic fail_hit;
  scg_pkg::scg_src_e cur_r;
  logic [5:0]        osc_en_r;

  // A loss counts only when the source was seen enabled and ready the cycle before
  assign xosc_loss = fail_mon_en_in & xosc_seen_r & ~rdy[scg_pkg::SRC_XOSC];
  assign pll_loss  = fail_mon_en_in & pll_seen_r & ~rdy[scg_pkg::SRC_PLL];
  assign fail_hit  = xosc_loss | pll_loss;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      xosc_seen_r <= 1'b0;
      pll_seen_r  <= 1'b0;
    end else begin
      xosc_seen_r <= osc_en_r[scg_pkg::SRC_XOSC] & rdy[scg_pkg::SRC_XOSC];
      pll_seen_r  <= osc_en_r[scg_pkg::SRC_PLL] & rdy[scg_pkg::SRC_PLL];
    end
  end

  // Sticky flags; a new loss beats a clear in the same cycle
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      xosc_fail_out <= 1'b0;
      pll_fail_out  <= 1'b0;
      nmi_out       <= 1'b0;
    end else begin
      xosc_fail_out <= xosc_loss | (xosc_fail_out & ~fail_clr_in);
      pll_fail_out  <= pll_loss | (pll_fail_out & ~fail_clr_in);
      nmi_out       <= (fail_hit & nmi_en_in) | (nmi_out & ~fail_clr_in);
    end
  end

  chk_nmi_raise: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    fail_hit && nmi_en_in |=> nmi_out) else $error("NMI not raised on failure");
  chk_nmi_optional: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $rose(nmi_out) |-> $past(fail_hit && nmi_en_in)) else $error("NMI raised without enabled failure");

  //----------------------------------------------------------------
  // System source switching
  //----------------------------------------------------------------
  scg_pkg::scg_src_e req;
  logic              req_ok;

  assign req    = scg_pkg::scg_src_e'(req_src_in);
  assign req_ok = (req_src_in <= 3'(scg_pkg::SRC_PLL)) && rdy[req_src_in] && osc_en_r[req_src_in];

  // Failure fallback wins; otherwise move only onto a running source
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cur_r <= scg_pkg::SRC_RC2M;
    end else if (fail_hit) begin
      cur_r <= scg_pkg::SRC_RC2M;
    end else if (req != cur_r && req_ok) begin
      cur_r <= req;
    end
  end

  assign sys_src_out = cur_r;

  chk_reset_src: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> sys_src_out == 3'(scg_pkg::SRC_RC2M)) else $error("Not on 2MHz after reset");
  chk_switch_ready: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $changed(sys_src_out) && sys_src_out != 3'(scg_pkg::SRC_RC2M)
    |-> $past(rdy[req_src_in] && osc_en_r[req_src_in]))
    else $error("Switched to a source that was not ready");
  chk_fail_fallback: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    fail_hit |=> sys_src_out == 3'(scg_pkg::SRC_RC2M)) else $error("No fallback after failure");

  //----------------------------------------------------------------
  // Oscillator enables
  //----------------------------------------------------------------
  logic [5:0]  in_use;
  logic [21:0] pll_khz;
  logic [16:0] pll_ref_khz;
  logic        pll_ok;

  // PLL reference: 2MHz, 32MHz/4 or the main crystal
  always_comb begin
    pll_ref_khz = scg_pkg::RC2M_KHZ;
    if (pll_ref_in == 2'h1) begin
      pll_ref_khz = scg_pkg::RC32M_DIV4_KHZ;
    end else if (pll_ref_in == 2'h2) begin
      pll_ref_khz = 17'(XOSC_KHZ);
    end
  end

  assign pll_khz = 22'(pll_mult_in) * 22'(pll_ref_khz);
  // Out-of-range factors or frequencies keep the PLL off
  assign pll_ok = pll_mult_in >= scg_pkg::PLL_MULT_MIN && pll_mult_in <= scg_pkg::PLL_MULT_MAX
               && pll_khz >= scg_pkg::PLL_KHZ_MIN && pll_khz <= scg_pkg::PLL_KHZ_MAX;

  // Keep whatever feeds the running clock, a pending request or the PLL alive
  always_comb begin
    in_use = osc_sw_en_in;
    in_use[cur_r] = 1'b1;
    if (req_src_in <= 3'(scg_pkg::SRC_PLL)) begin
      in_use[req_src_in] = 1'b1;
    end
    in_use[scg_pkg::SRC_PLL] = (in_use[scg_pkg::SRC_PLL] | pll_sw_en_in) & pll_ok;
    if (in_use[scg_pkg::SRC_PLL]) begin
      in_use[pll_ref_in == 2'h2 ? scg_pkg::SRC_XOSC
            : pll_ref_in == 2'h1 ? scg_pkg::SRC_RC32M : scg_pkg::SRC_RC2M] = 1'b1;
    end
    if (digital_freq_lock_loop_en_in != 2'h0) begin
      in_use[digital_freq_lock_loop_ref_in ? scg_pkg::SRC_XTAL32K : scg_pkg::SRC_RC32K] = 1'b1;
    end
    if (rtc_src_in == 2'(scg_pkg::RTC_RC32K)) begin
      in_use[scg_pkg::SRC_RC32K] = 1'b1;
    end
    if (rtc_src_in == 2'(scg_pkg::RTC_XTAL32K)) begin
      in_use[scg_pkg::SRC_XTAL32K] = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      osc_en_r     <= scg_pkg::OSC_EN_RST;
      ulp_en_out   <= 1'b1;
      pll_mult_out <= scg_pkg::PLL_MULT_MIN;
    end else begin
      osc_en_r     <= in_use;
      ulp_en_out   <= (rtc_src_in == 2'(scg_pkg::RTC_ULP)) | ulp_user_in;
      pll_mult_out <= pll_mult_in;
    end
  end

  assign osc_en_out = osc_en_r;

  // Mode straps for the analog cells
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rtc_src_out           <= 2'(scg_pkg::RTC_ULP);
      xosc_mode_out         <= 2'h0;
      xosc_ext_clk_out      <= 1'b0;
      xtal32k_low_swing_out <= 1'b0;
      pll_locked_out        <= 1'b0;
    end else begin
      rtc_src_out           <= rtc_src_in;
      xosc_mode_out         <= xosc_mode_in;
      xosc_ext_clk_out      <= xosc_ext_clk_in;
      xtal32k_low_swing_out <= xtal32k_low_swing_in;
      pll_locked_out        <= osc_en_r[scg_pkg::SRC_PLL] & rdy[scg_pkg::SRC_PLL];
    end
  end

  chk_osc_reset_off: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> osc_en_out == 6'h00 && ulp_en_out) else $error("Sources not off after reset");
  chk_ulp_auto: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    rtc_src_in == 2'h0 |=> ulp_en_out) else $error("Low-power oscillator not enabled for RTC");
  chk_pll_range: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    osc_en_out[5] |-> $past(pll_mult_in) != 5'h00 && $past(pll_khz) <= 22'h01f400)
    else $error("PLL enabled out of range");

  //----------------------------------------------------------------
  // Prescaler and fast peripheral ticks
  //----------------------------------------------------------------
  logic [10:0] div_cnt_r;
  logic [10:0] div_last;
  logic [3:0]  exp_sel;
  logic [3:0]  exp_r;
  logic [1:0]  sub_r;
  logic        per4_hit;

  assign exp_sel  = (div_exp_in > scg_pkg::DIV_EXP_MAX) ? scg_pkg::DIV_EXP_MAX : div_exp_in;
  assign div_last = 11'((12'h001 << exp_sel) - 12'h001);
  assign per4_hit = (div_cnt_r >= div_last);

  // Restart the chain on a setting change so no short tick slips out
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      div_cnt_r <= 11'h000;
      exp_r     <= 4'h0;
      sub_r     <= 2'h0;
    end else begin
      exp_r <= exp_sel;
      if (exp_sel != exp_r || per4_hit) begin
        div_cnt_r <= 11'h000;
      end else begin
        div_cnt_r <= div_cnt_r + 11'h001;
      end
      if (exp_sel != exp_r) begin
        sub_r <= 2'h0;
      end else if (per4_hit) begin
        sub_r <= sub_r + 2'h1;
      end
    end
  end

  // Ticks derive from one chain, so 4x, 2x and CPU stay phase aligned
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      per4_tick_out <= 1'b0;
      per2_tick_out <= 1'b0;
      cpu_tick_out  <= 1'b0;
    end else begin
      per4_tick_out <= per4_hit && exp_sel == exp_r;
      per2_tick_out <= per4_hit && exp_sel == exp_r && sub_r[0];
      cpu_tick_out  <= per4_hit && exp_sel == exp_r && sub_r == 2'h3;
    end
  end

  chk_fast_ratio: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    cpu_tick_out |-> per2_tick_out && per4_tick_out) else $error("Fast ticks out of step with CPU");

  //----------------------------------------------------------------
  // Sleep and power-reduction gating
  //----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cpu_clk_en_out <= 1'b1;
      per_clk_en_out <= '1;
    end else begin
      cpu_clk_en_out <= ~(idle_sleep_in | pdown_sleep_in);
      per_clk_en_out <= ~pwr_reduce_in & {PER_N{~pdown_sleep_in}};
    end
  end

  chk_cpu_gate: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    idle_sleep_in |=> !cpu_clk_en_out) else $error("CPU clock not gated in sleep");

  //----------------------------------------------------------------
  // 32.768kHz oscillator divider and calibration
  //----------------------------------------------------------------
  logic [4:0] k_div_r;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      k_div_r        <= 5'h00;
      rc32k_tick_out <= 1'b0;
      rc1k_tick_out  <= 1'b0;
      rc32k_cal_out  <= scg_pkg::RC32K_CAL_RST;
      usb48_cal_out  <= USB48_CAL;
    end else begin
      rc32k_tick_out <= rc32k_rise;
      rc1k_tick_out  <= rc32k_rise && k_div_r == scg_pkg::RC1K_DIV_LAST;
      if (rc32k_rise) begin
        k_div_r <= k_div_r + 5'h01;
      end
      if (cal_wr_in[2]) begin
        rc32k_cal_out <= cal_data_in;
      end
      usb48_cal_out <= USB48_CAL;
    end
  end

  chk_rc32k_cal: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    cal_wr_in[2] |=> rc32k_cal_out == $past(cal_data_in)) else $error("32k calibration write lost");

  //----------------------------------------------------------------
  // Frequency-locked loops for 2MHz and 32MHz oscillators
  //----------------------------------------------------------------
  logic       ref_rise;
  logic [7:0] fb_cnt_r [2];
  logic [7:0] cal_r    [2];
  logic [7:0] target   [2];

  assign ref_rise  = digital_freq_lock_loop_ref_in ? xtal32k_rise : rc32k_rise;
  assign target[0] = scg_pkg::DIGITAL_FREQ_LOCK_LOOP_2M_TARGET;
  assign target[1] = dfll32_target_in;

  // Count feedback edges per reference period and nudge trim one step
  for (genvar g = 0; g < 2; g++) begin : g_digital_freq_lock_loop
    always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
        fb_cnt_r[g] <= 8'h00;
        cal_r[g]    <= (g == 0) ? scg_pkg::RC2M_CAL_RST : scg_pkg::RC32M_CAL_RST;
      end else begin
        if (ref_rise) begin
          fb_cnt_r[g] <= 8'h00;
        end else if (fb_rise[g] && fb_cnt_r[g] != 8'hff) begin
          fb_cnt_r[g] <= fb_cnt_r[g] + 8'h01;
        end
        if (cal_wr_in[g]) begin
          cal_r[g] <= cal_data_in;
        end else if (g == 1 && usb48_load_in) begin
          cal_r[g] <= USB48_CAL;
        end else if (digital_freq_lock_loop_en_in[g] && ref_rise && fb_cnt_r[g] < target[g] && cal_r[g] != 8'hff) begin
          cal_r[g] <= cal_r[g] + 8'h01;
        end else if (digital_freq_lock_loop_en_in[g] && ref_rise && fb_cnt_r[g] > target[g] && cal_r[g] != 8'h00) begin
          cal_r[g] <= cal_r[g] - 8'h01;
        end
      end
    end
  end

  assign rc2m_cal_out  = cal_r[0];
  assign rc32m_cal_out = cal_r[1];

  chk_digital_freq_lock_loop_step: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !cal_wr_in[0] && !digital_freq_lock_loop_en_in[0] |=> $stable(rc2m_cal_out)) else $error("2MHz trim moved while loop off");
  chk_usb_load: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    usb48_load_in && !cal_wr_in[1] |=> rc32m_cal_out == usb48_cal_out) else $error("48MHz trim not loaded");

endmodule

// [testbench/system_clock_generation_tb.sv]
// Self-checking testbench for the system clock generation block
`timescale 1ns/1ps

module system_clock_generation_tb;
  //------------------------------------------------------------------
  // Signals
  //------------------------------------------------------------------
  logic       clock_in, sys_rst_in, ulp_user_in, xosc_ext_clk_in, xtal32k_low_swing_in, pll_sw_en_in;
  logic       usb48_load_in, digital_freq_lock_loop_ref_in, fail_mon_en_in, nmi_en_in, fail_clr_in, idle_sleep_in;
  logic       pdown_sleep_in, pll_lock_in, rc32k_clk_in, xtal32k_clk_in, fb2m_in, fb32m_in;
  logic [2:0] req_src_in, cal_wr_in, sys_src_out;
  logic [5:0] osc_sw_en_in, osc_en_out;
  logic [1:0] rtc_src_in, xosc_mode_in, pll_ref_in, digital_freq_lock_loop_en_in, rtc_src_out, xosc_mode_out;
  logic [3:0] div_exp_in;
  logic [4:0] pll_mult_in, osc_ready_in, pll_mult_out;
  logic [7:0] cal_data_in, dfll32_target_in, pwr_reduce_in, per_clk_en_out;
  logic [7:0] rc2m_cal_out, rc32m_cal_out, rc32k_cal_out, usb48_cal_out;
  logic       ulp_en_out, xosc_ext_clk_out, xtal32k_low_swing_out, per4_tick_out, per2_tick_out;
  logic       cpu_tick_out, cpu_clk_en_out, pll_locked_out, rc32k_tick_out, rc1k_tick_out;
  logic       xosc_fail_out, pll_fail_out, nmi_out;
  int         fails, n_checks, i, k, g;

  scg_clock_ctrl #(.PER_N(8), .XOSC_KHZ(16000), .USB48_CAL(8'h9c)) i_scg_clock_ctrl (
    .clock_in, .sys_rst_in, .req_src_in, .osc_sw_en_in, .rtc_src_in, .ulp_user_in, .xosc_mode_in,
    .xosc_ext_clk_in, .xtal32k_low_swing_in, .div_exp_in, .pll_sw_en_in, .pll_mult_in, .pll_ref_in,
    .cal_wr_in, .cal_data_in, .usb48_load_in, .digital_freq_lock_loop_en_in, .digital_freq_lock_loop_ref_in, .dfll32_target_in,
    .fail_mon_en_in, .nmi_en_in, .fail_clr_in, .idle_sleep_in, .pdown_sleep_in, .pwr_reduce_in,
    .osc_ready_in, .pll_lock_in, .rc32k_clk_in, .xtal32k_clk_in, .fb2m_in, .fb32m_in, .sys_src_out,
    .osc_en_out, .ulp_en_out, .rtc_src_out, .xosc_mode_out, .xosc_ext_clk_out, .xtal32k_low_swing_out,
    .per4_tick_out, .per2_tick_out, .cpu_tick_out, .cpu_clk_en_out, .per_clk_en_out, .pll_mult_out,
    .pll_locked_out, .rc2m_cal_out, .rc32m_cal_out, .rc32k_cal_out, .usb48_cal_out, .rc32k_tick_out,
    .rc1k_tick_out, .xosc_fail_out, .pll_fail_out, .nmi_out);

  //------------------------------------------------------------------
  // Helpers
  //------------------------------------------------------------------
  // Inputs always move 1ns after the edge so outputs of that edge have settled
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t %s: got %0h want %0h", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Pick one tick output; sel 0=per4 1=per2 2=cpu
  function automatic logic tick_sel(input int sel);
    tick_sel = (sel == 0) ? per4_tick_out : (sel == 1) ? per2_tick_out : cpu_tick_out;
  endfunction

  // Cycles between two pulses of one tick
  task automatic gap(input int sel, output int n);
    for (n = 0; n < 20000 && tick_sel(sel) !== 1'b1; n++) step(1);
    n = 0;
    do begin
      step(1);
      n++;
    end while (n < 20000 && tick_sel(sel) !== 1'b1);
  endtask

  //------------------------------------------------------------------
  // Scenarios
  //------------------------------------------------------------------
  task automatic t_reset();
    sys_rst_in = 1'b1;
    step(3);
    sys_rst_in = 1'b0;
    chk(osc_en_out, 6'h00, "sources off");
    chk(ulp_en_out, 1'b1, "low power osc on");
    chk(sys_src_out, 3'h0, "start source");
    chk({rc2m_cal_out, rc32m_cal_out, rc32k_cal_out, usb48_cal_out}, 32'h4040809c, "trims");
    step(1);
    chk(osc_en_out[0], 1'b1, "2MHz osc in use");
  endtask

  // Switch to the crystal must wait for ready, then failures fall back with optional NMI
  task automatic t_switch_fail();
    req_src_in = 3'h3;
    step(20);
    chk(sys_src_out, 3'h0, "switch refused");
    chk(osc_en_out[3], 1'b1, "request enables");
    fail_mon_en_in = 1'b1;
    for (k = 0; k < 2; k++) begin
      nmi_en_in = k[0];
      osc_ready_in[3] = 1'b1;
      for (i = 0; i < 10 && sys_src_out !== 3'h3; i++) step(1);
      chk(sys_src_out, 3'h3, "switch taken");
      osc_ready_in[3] = 1'b0;
      for (i = 0; i < 10 && sys_src_out !== 3'h0; i++) step(1);
      chk(sys_src_out, 3'h0, "fallback");
      chk({xosc_fail_out, nmi_out}, {1'b1, k[0]}, "fail flags");
      fail_clr_in = 1'b1;
      step(1);
      fail_clr_in = 1'b0;
      step(1);
      chk({xosc_fail_out, nmi_out, pll_fail_out}, 3'h0, "flags cleared");
    end
    req_src_in = 3'h0;
  endtask

  // Tick spacing for unclamped, small and clamped exponents
  task automatic t_prescale();
    int e[3] = '{0, 2, 15};
    for (k = 0; k < 3; k++) begin
      div_exp_in = e[k][3:0];
      step(2);
      for (i = 0; i < 3; i++) begin
        gap(i, g);
        chk(g, (1 << (e[k] > 11 ? 11 : e[k])) << i, "tick gap");
      end
    end
  endtask

  task automatic t_pll(input logic [1:0] rf, input logic [4:0] m, input logic en);
    pll_ref_in = rf;
    pll_mult_in = m;
    step(4);
    chk(pll_mult_out, m, "pll factor");
    chk(osc_en_out[5], en, "pll range");
    chk(pll_locked_out, en, "pll lock");
  endtask

  task automatic t_cal_div();
    cal_data_in = 8'h5a;
    cal_wr_in = 3'h4;
    step(1);
    cal_wr_in = 3'h0;
    chk(rc32k_cal_out, 8'h5a, "trim write");
    usb48_load_in = 1'b1;
    step(1);
    usb48_load_in = 1'b0;
    chk(rc32m_cal_out, 8'h9c, "usb trim load");
    digital_freq_lock_loop_en_in = 2'b01;
    g = -1;
    for (i = 0; i < 600; i++) begin
      if (i % 4 == 0) rc32k_clk_in = ~rc32k_clk_in;
      step(1);
      if (rc32k_tick_out === 1'b1 && g >= 0) g++;
      if (rc1k_tick_out === 1'b1) begin
        chk(rc32k_tick_out, 1'b1, "coincident");
        if (g >= 0) chk(g, 32, "1k divide");
        g = 0;
      end
    end
    chk(rc2m_cal_out > 8'h40, 1'b1, "loop trims up");
    digital_freq_lock_loop_en_in = 2'b00;
  endtask

  task automatic t_gate_misc();
    idle_sleep_in = 1'b1;
    step(2);
    chk({cpu_clk_en_out, per_clk_en_out}, 9'h0ff, "idle");
    pdown_sleep_in = 1'b1;
    step(2);
    chk({cpu_clk_en_out, per_clk_en_out}, 9'h000, "power down");
    {idle_sleep_in, pdown_sleep_in, pwr_reduce_in} = {2'b00, 8'h0f};
    step(2);
    chk({cpu_clk_en_out, per_clk_en_out}, 9'h1f0, "reduce");
    rtc_src_in = 2'h1;
    step(3);
    chk({rtc_src_out, ulp_en_out}, 3'h2, "ulp unused");
    ulp_user_in = 1'b1;
    step(3);
    chk(ulp_en_out, 1'b1, "ulp user");
    for (k = 0; k < 4; k++) begin
      {xosc_mode_in, xosc_ext_clk_in, xtal32k_low_swing_in} = {k[1:0], k[0], ~k[0]};
      step(2);
      chk({xosc_mode_out, xosc_ext_clk_out, xtal32k_low_swing_out}, {k[1:0], k[0], ~k[0]}, "straps");
    end
  endtask

  //------------------------------------------------------------------
  // Clock, stimulus and watchdog
  //------------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  initial begin
    {fails, n_checks} = '0;
    {sys_rst_in, ulp_user_in, xosc_ext_clk_in, xtal32k_low_swing_in, pll_sw_en_in, usb48_load_in} = '0;
    {digital_freq_lock_loop_ref_in, fail_mon_en_in, nmi_en_in, fail_clr_in, idle_sleep_in, pdown_sleep_in} = '0;
    {pll_lock_in, rc32k_clk_in, xtal32k_clk_in, fb2m_in, fb32m_in, req_src_in, cal_wr_in} = '0;
    {osc_sw_en_in, rtc_src_in, xosc_mode_in, pll_ref_in, digital_freq_lock_loop_en_in, div_exp_in} = '0;
    {pll_mult_in, cal_data_in, dfll32_target_in, pwr_reduce_in} = '0;
    osc_ready_in = 5'h07;
    t_reset();
    t_switch_fail();
    t_prescale();
    pll_sw_en_in = 1'b1;
    pll_lock_in = 1'b1;
    t_pll(2'h0, 5'h01, 1'b0);
    t_pll(2'h0, 5'h0a, 1'b1);
    t_pll(2'h0, 5'h1f, 1'b1);
    pll_lock_in = 1'b0;
    step(4);
    chk(pll_fail_out, 1'b1, "pll unlock flagged");
    chk(sys_src_out, 3'h0, "pll unlock fallback");
    pll_lock_in = 1'b1;
    fail_clr_in = 1'b1;
    step(4);
    fail_clr_in = 1'b0;
    chk(pll_fail_out, 1'b0, "pll flag cleared");
    t_pll(2'h2, 5'h09, 1'b0);
    t_cal_div();
    t_gate_misc();
    complete_run();
  end

  // Longest path is the clamped prescaler run, well under this span
  initial begin
    #(25 * 120000);
    fails++;
    complete_run();
  end
endmodule
